// *** src/ept_defs.svh ***
`ifndef EPT_DEFS_SVH
`define EPT_DEFS_SVH
// register byte addresses
`define EPT_ADDR_COUNT 8'h00
`define EPT_ADDR_CTRL 8'h04
`define EPT_ADDR_PERIOD 8'h08
`define EPT_ADDR_STATUS 8'h0C
`define EPT_ADDR_MASK 8'h10
// control field positions
`define EPT_CTRL_PRE_LSB 0
`define EPT_CTRL_PRE_MSB 1
`define EPT_CTRL_RUN_BIT 2
`define EPT_CTRL_POST_LSB 3
`define EPT_CTRL_POST_MSB 6
`define EPT_CTRL_IMPL_MASK 8'h7F
// status bit of the period event flag
`define EPT_STAT_EVT_BIT 3
// reset values
`define EPT_RST_COUNT 8'h00
`define EPT_RST_CTRL 8'h00
`define EPT_RST_PERIOD 8'hFF
// instruction clock is the core clock divided by four
`define EPT_INSTR_DIV 4
`endif

// *** src/ept_pkg.sv ***
package ept_pkg;
	typedef enum logic [1:0] {EPT_DIV1, EPT_DIV4, EPT_DIV16} ept_div_t;
	typedef logic [7:0] ept_byte_t;
endpackage

// *** src/ept_tick_if.sv ***
`timescale 1ns/100ps
// carries divider control and ticks between the timer and its dividers
interface ept_tick_if;
	logic clear;
	logic run;
	logic [1:0] preSel;
	logic [3:0] postSel;
	logic countTick;
	logic match;
	logic postDone;
	modport core (output clear, run, preSel, postSel, match,
		input countTick, postDone);
	modport divs (input clear, run, preSel, postSel, match,
		output countTick, postDone);
endinterface

// *** src/ept_dividers.sv ***
`timescale 1ns/100ps
`include "ept_defs.svh"
// instruction-cycle divider, prescaler and postscaler
module ept_dividers (
	input wire logic clk,
	input wire logic reset_n,
	ept_tick_if.divs tick
);
	import ept_pkg::*;

	logic [1:0] instrCnt_r;
	logic [3:0] preCnt_r;
	logic [3:0] postCnt_r;
	logic instrTick;
	logic [3:0] preLast;

	// prescale ratio decode, 1x codes mean sixteen
	function automatic logic [3:0] pre_last(input logic [1:0] sel);
		case (sel)
			2'b00: pre_last = 4'h0;
			2'b01: pre_last = 4'h3;
			default: pre_last = 4'hF;
		endcase
	endfunction

	assign instrTick = (instrCnt_r == 2'(`EPT_INSTR_DIV - 1)) && tick.run;
	assign preLast = pre_last(tick.preSel);
	// a divider clear swallows a tick in flight, so a control write
	// can never move the count in the cycle that it lands
	assign tick.countTick = instrTick && (preCnt_r == preLast) &&
		!tick.clear;
	assign tick.postDone = tick.match && (postCnt_r == tick.postSel);

	// instruction-cycle phase; stops with the timer to save power
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			instrCnt_r <= 2'h0;
		else if (tick.clear || !tick.run)
			instrCnt_r <= 2'h0;
		else
			instrCnt_r <= instrCnt_r + 2'h1;
	end

	// prescaler
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			preCnt_r <= 4'h0;
		else if (tick.clear)
			preCnt_r <= 4'h0;
		else if (instrTick)
			preCnt_r <= (preCnt_r == preLast) ? 4'h0 : preCnt_r + 4'h1;
	end

	// postscaler counts matches
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			postCnt_r <= 4'h0;
		else if (tick.clear)
			postCnt_r <= 4'h0;
		else if (tick.match)
			postCnt_r <= tick.postDone ? 4'h0 : postCnt_r + 4'h1;
	end

	// prescaler never passes its last value
	property p_pre16;
		@(posedge clk) disable iff (!reset_n)
		preCnt_r <= preLast || tick.clear || $changed(tick.preSel);
	endproperty
	a_pre16: assert property (p_pre16)
		else $error("prescaler out of range");

	// postscaler never passes the selected ratio
	property p_post_range;
		@(posedge clk) disable iff (!reset_n)
		postCnt_r <= tick.postSel || $changed(tick.postSel);
	endproperty
	a_post_range: assert property (p_post_range)
		else $error("postscaler out of range");
endmodule // ept_dividers

// *** src/ept_period_timer.sv ***
`timescale 1ns/100ps
`include "ept_defs.svh"
// Summary of operation
// - counts at clock/4 through the prescaler.
// - input divider select 00 gives 1, 01 gives 4, 1x gives 16.
// - count rises to the match value then wraps to zero next tick.
// - match divider select n gives a postscale of n+1.
// - each postscaled match sets the period event flag, status bit 3.
// - dividers clear on count write, control write and reset.
// - a control write leaves the count unchanged.
// - count register is read/write and resets to zero.
// - match value register is read/write and resets to all ones.
// - the prescaled match pulse is offered to the PWM units.
// - the match pulse feeds both the PWM output and the postscaler.
// - control bit 7 reads zero and ignores writes.
module ept_period_timer (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic pwmTimeBase,
	output logic irq,
	output ept_pkg::ept_byte_t countValue
);
	import ept_pkg::*;

	//==========================================
	// bus slave
	logic wrPend_r;
	logic [7:0] wrAddr_r;
	logic rdEn;
	logic wrEn;
	ept_byte_t count_r;
	ept_byte_t ctrl_r;
	ept_byte_t period_r;
	ept_byte_t status_r;
	ept_byte_t mask_r;
	ept_tick_if tick();

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign rdEn = hsel && hready && htrans[1] && !hwrite;
	assign wrEn = wrPend_r;

	// write address captured for the data phase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
		end else begin
			wrPend_r <= hsel && hready && htrans[1] && hwrite;
			wrAddr_r <= haddr;
		end
	end

	// read data registered at the address phase; unmapped reads zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			hrdata <= 32'h0000_0000;
		else if (rdEn) begin
			case (haddr)
				`EPT_ADDR_COUNT: hrdata <= {24'h00_0000, count_r};
				`EPT_ADDR_CTRL: hrdata <= {24'h00_0000, ctrl_r};
				`EPT_ADDR_PERIOD: hrdata <= {24'h00_0000, period_r};
				`EPT_ADDR_STATUS: hrdata <= {24'h00_0000, status_r};
				`EPT_ADDR_MASK: hrdata <= {24'h00_0000, mask_r};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	//==========================================
	// control, match and mask registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			ctrl_r <= `EPT_RST_CTRL;
		else if (wrEn && wrAddr_r == `EPT_ADDR_CTRL)
			ctrl_r <= hwdata[7:0] & `EPT_CTRL_IMPL_MASK;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			period_r <= `EPT_RST_PERIOD;
		else if (wrEn && wrAddr_r == `EPT_ADDR_PERIOD)
			period_r <= hwdata[7:0];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			mask_r <= 8'h00;
		else if (wrEn && wrAddr_r == `EPT_ADDR_MASK)
			mask_r <= hwdata[7:0];
	end

	//==========================================
	// dividers
	assign tick.clear = wrEn && (wrAddr_r == `EPT_ADDR_COUNT ||
		wrAddr_r == `EPT_ADDR_CTRL);
	assign tick.run = ctrl_r[`EPT_CTRL_RUN_BIT];
	assign tick.preSel = ctrl_r[`EPT_CTRL_PRE_MSB:`EPT_CTRL_PRE_LSB];
	assign tick.postSel = ctrl_r[`EPT_CTRL_POST_MSB:`EPT_CTRL_POST_LSB];
	// match fires on the tick that wraps the count
	assign tick.match = tick.countTick && (count_r == period_r);

	ept_dividers u_div (
		.clk(clk),
		.reset_n(reset_n),
		.tick(tick)
	);

	//==========================================
	// counter; a control write does not touch it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			count_r <= `EPT_RST_COUNT;
		else if (wrEn && wrAddr_r == `EPT_ADDR_COUNT)
			count_r <= hwdata[7:0];
		else if (tick.match)
			count_r <= 8'h00;
		else if (tick.countTick)
			count_r <= count_r + 8'h01;
	end

	// pwm time base, before the postscaler; no other consumer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			pwmTimeBase <= 1'b0;
		else
			pwmTimeBase <= tick.match;
	end

	assign countValue = count_r;

	//==========================================
	// sticky status, cleared by read; a new event beats the clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			status_r <= 8'h00;
		else if (tick.postDone)
			status_r[`EPT_STAT_EVT_BIT] <= 1'b1;
		else if (rdEn && haddr == `EPT_ADDR_STATUS)
			status_r <= 8'h00;
	end

	assign irq = |(status_r & mask_r);

	//==========================================
	// checks
	property p_wrap;
		@(posedge clk) disable iff (!reset_n)
		tick.match && !wrEn |=> count_r == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap");

	property p_ctrl_keep;
		@(posedge clk) disable iff (!reset_n)
		wrEn && wrAddr_r == `EPT_ADDR_CTRL |=> count_r == $past(count_r);
	endproperty
	a_ctrl_keep: assert property (p_ctrl_keep)
		else $error("control write changed count");

	property p_stop;
		@(posedge clk) disable iff (!reset_n)
		!tick.run |-> !tick.countTick;
	endproperty
	a_stop: assert property (p_stop)
		else $error("counting while off");

	property p_flag;
		@(posedge clk) disable iff (!reset_n)
		tick.postDone |=> status_r[`EPT_STAT_EVT_BIT];
	endproperty
	a_flag: assert property (p_flag) else $error("flag not set");

	property p_sticky;
		@(posedge clk) disable iff (!reset_n)
		status_r[3] && !(rdEn && haddr == `EPT_ADDR_STATUS) |=> status_r[3];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");

	property p_bit7;
		@(posedge clk) disable iff (!reset_n)
		!ctrl_r[7];
	endproperty
	a_bit7: assert property (p_bit7) else $error("bit 7 set");

	property p_tick4;
		@(posedge clk) disable iff (!reset_n)
		tick.countTick && tick.run && !tick.clear |=> !tick.countTick[*3];
	endproperty
	a_tick4: assert property (p_tick4)
		else $error("tick too fast");

	// irq may only rise after an event or a mask write
	property p_irq;
		@(posedge clk) disable iff (!reset_n)
		$rose(irq) |-> $past(tick.postDone) ||
			($past(wrEn) && $past(wrAddr_r) == `EPT_ADDR_MASK);
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq rose with no cause");

	//==========================================
	// counter, register and output checks

	property p_count_step;
		@(posedge clk) disable iff (!reset_n)
		tick.countTick && !tick.match |=> count_r == $past(count_r) + 8'h01;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("count did not advance");

	// a stopped timer must hold its count
	property p_count_hold;
		@(posedge clk) disable iff (!reset_n)
		!tick.countTick && !(wrEn && wrAddr_r == `EPT_ADDR_COUNT)
			|=> count_r == $past(count_r);
	endproperty
	a_count_hold: assert property (p_count_hold)
		else $error("count moved without a tick");

	// cleared dividers need a full instruction cycle before a tick
	property p_clear;
		@(posedge clk) disable iff (!reset_n)
		tick.clear |=> !tick.countTick[*3];
	endproperty
	a_clear: assert property (p_clear)
		else $error("tick too soon after divider clear");

	property p_count_write;
		@(posedge clk) disable iff (!reset_n)
		wrEn && wrAddr_r == `EPT_ADDR_COUNT |=> count_r == $past(hwdata[7:0]);
	endproperty
	a_count_write: assert property (p_count_write)
		else $error("count write lost");

	property p_period_write;
		@(posedge clk) disable iff (!reset_n)
		wrEn && wrAddr_r == `EPT_ADDR_PERIOD
			|=> period_r == $past(hwdata[7:0]);
	endproperty
	a_period_write: assert property (p_period_write)
		else $error("period write lost");

	property p_rd_count;
		@(posedge clk) disable iff (!reset_n)
		rdEn && haddr == `EPT_ADDR_COUNT
			|=> hrdata == {24'h00_0000, $past(count_r)};
	endproperty
	a_rd_count: assert property (p_rd_count)
		else $error("count read wrong");

	property p_rd_period;
		@(posedge clk) disable iff (!reset_n)
		rdEn && haddr == `EPT_ADDR_PERIOD
			|=> hrdata == {24'h00_0000, $past(period_r)};
	endproperty
	a_rd_period: assert property (p_rd_period)
		else $error("period read wrong");

	property p_rd_ctrl;
		@(posedge clk) disable iff (!reset_n)
		rdEn && haddr == `EPT_ADDR_CTRL |=> !hrdata[7];
	endproperty
	a_rd_ctrl: assert property (p_rd_ctrl)
		else $error("control bit 7 read as one");

	property p_post_match;
		@(posedge clk) disable iff (!reset_n)
		tick.postDone |-> tick.match;
	endproperty
	a_post_match: assert property (p_post_match)
		else $error("postscaler fired without a match");

	property p_status_clear;
		@(posedge clk) disable iff (!reset_n)
		rdEn && haddr == `EPT_ADDR_STATUS && !tick.postDone
			|=> status_r == 8'h00;
	endproperty
	a_status_clear: assert property (p_status_clear)
		else $error("status read did not clear");

	// irq may only fall after a status read or a mask write
	property p_irq_fall;
		@(posedge clk) disable iff (!reset_n)
		$fell(irq) |-> ($past(rdEn) && $past(haddr) == `EPT_ADDR_STATUS) ||
			($past(wrEn) && $past(wrAddr_r) == `EPT_ADDR_MASK);
	endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("irq fell with no cause");

	property p_pwm;
		@(posedge clk) disable iff (!reset_n)
		pwmTimeBase == $past(tick.match);
	endproperty
	a_pwm: assert property (p_pwm)
		else $error("time base does not follow the match");

	// ticks are at least four clocks apart, so the pulse is single
	property p_pwm_pulse;
		@(posedge clk) disable iff (!reset_n)
		pwmTimeBase |=> !pwmTimeBase;
	endproperty
	a_pwm_pulse: assert property (p_pwm_pulse)
		else $error("time base pulse too long");

	c_match: cover property (@(posedge clk) tick.match);
	c_flag: cover property (@(posedge clk) tick.postDone);
	c_irq: cover property (@(posedge clk) irq);
	c_ctrl_write: cover property (@(posedge clk) tick.clear && tick.run);
	c_irq_clear: cover property (@(posedge clk) $fell(irq));
endmodule // ept_period_timer

// *** testbench/ept_pwm_model.sv ***
`timescale 1ns/100ps
// ========
// pwm units: only count the time base pulses
module ept_pwm_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic timeBase,
	output logic [15:0] edgeCount
);
	// one count per pulse, each starts a pwm period
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			edgeCount <= 16'h0000;
		else if (timeBase)
			edgeCount <= edgeCount + 16'h0001;
	end
endmodule // ept_pwm_model

// *** testbench/ept_period_timer_bench.sv ***
`timescale 1ns/100ps
`include "ept_defs.svh"
// ========
// bus master, pwm model and checks
module ept_period_timer_bench;
	import ept_pkg::*;
	logic clk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
	logic pwmTimeBase, irq;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd;
	ept_byte_t countValue;
	logic [15:0] pulses, p0;
	int badCount = 0;
	int compares = 0;
	int n;
	int post [3] = '{0, 1, 15};
	assign hready = hreadyout; // single slave
	ept_period_timer i_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pwmTimeBase(pwmTimeBase),
		.irq(irq), .countValue(countValue));
	ept_pwm_model i_pwm (.clk(clk), .reset_n(reset_n),
		.timeBase(pwmTimeBase), .edgeCount(pulses));
	// 125 MHz
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ========
	// tasks
	task automatic giveVerdict;
		$display("compares %0d mismatches %0d", compares, badCount);
		if (badCount == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// bounded wait, never trusts zero wait states
	task automatic waitReady;
		int k;
		k = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1) begin
			k++;
			if (k > 50) begin
				badCount++;
				giveVerdict;
			end
			@(posedge clk);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		waitReady;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		waitReady;
		rd = hrdata; // pre-edge value of the data phase
		check("hresp", 32'h0, 32'(hresp));
	endtask
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			badCount++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic rdChk(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		bus(a, 1'b0, 32'h0000_0000);
		check(what, exp, rd);
	endtask
	// clocks up to the next time base pulse
	task automatic waitPulse(output int g);
		g = 0;
		do begin
			@(posedge clk);
			g++;
			if (g > 3000) begin
				badCount++;
				giveVerdict;
			end
		end while (pwmTimeBase !== 1'b1);
	endtask
	// ========
	// tests
	initial begin
		reset_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 8'h00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		rdChk("count", `EPT_ADDR_COUNT, 32'h0000_0000);
		rdChk("ctrl", `EPT_ADDR_CTRL, 32'h0000_0000);
		rdChk("period", `EPT_ADDR_PERIOD, 32'h0000_00FF);
		bus(`EPT_ADDR_CTRL, 1'b1, 32'h0000_00FF);
		rdChk("ctrl", `EPT_ADDR_CTRL, 32'h0000_007F);
		rdChk("unmapped", 8'h20, 32'h0000_0000);
		$display("test registers done");
		// period 3: four ticks per match, each tick four clocks times the prescale ratio
		bus(`EPT_ADDR_PERIOD, 1'b1, 32'h0000_0003);
		rdChk("period", `EPT_ADDR_PERIOD, 32'h0000_0003);
		for (int c = 0; c < 4; c++) begin
			bus(`EPT_ADDR_CTRL, 1'b1, 32'(4 + c));
			waitPulse(n);
			waitPulse(n);
			check("gap", 32'(16 * (c == 0 ? 1 : c == 1 ? 4 : 16)), n);
		end
		$display("test prescale done");
		// postscale counted in pulses from a divider clear
		bus(`EPT_ADDR_MASK, 1'b1, 32'h0000_0008);
		foreach (post[i]) begin
			bus(`EPT_ADDR_CTRL, 1'b1, 32'(post[i] * 8));
			bus(`EPT_ADDR_STATUS, 1'b0, 32'h0000_0000);
			p0 = pulses;
			bus(`EPT_ADDR_CTRL, 1'b1, 32'(post[i] * 8 + 4));
			waitPulse(n);
			// bounded: a flag that never comes ends the run
			while (irq !== 1'b1) begin
				@(posedge clk);
				n++;
				if (n > 3000) begin
					badCount++;
					giveVerdict;
				end
			end
			repeat (4) @(posedge clk);
			check("post", 32'(post[i] + 1), 32'(pulses - p0));
		end
		// flag holds over more matches and through a stop
		bus(`EPT_ADDR_CTRL, 1'b1, 32'h0000_0004);
		waitPulse(n);
		waitPulse(n);
		// read two clocks after the match, before the next tick
		rdChk("wrap", `EPT_ADDR_COUNT, 32'h0000_0000);
		bus(`EPT_ADDR_CTRL, 1'b1, 32'h0000_0000);
		check("irq", 32'h1, 32'(irq));
		rdChk("status", `EPT_ADDR_STATUS, 32'h0000_0008);
		rdChk("status", `EPT_ADDR_STATUS, 32'h0000_0000);
		check("irq", 32'h0, 32'(irq));
		$display("test postscale done");
		// stopped: count held, control write keeps it
		bus(`EPT_ADDR_COUNT, 1'b1, 32'h0000_0055);
		bus(`EPT_ADDR_CTRL, 1'b1, 32'h0000_0003);
		repeat (100) @(posedge clk);
		rdChk("count", `EPT_ADDR_COUNT, 32'h0000_0055);
		check("countValue", 32'h55, 32'(countValue));
		$display("test hold done");
		// reset in mid-run: count back to zero, period to all ones
		bus(`EPT_ADDR_CTRL, 1'b1, 32'h0000_0004);
		repeat (20) @(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		check("pulse", 32'h0, 32'(pwmTimeBase));
		rdChk("count", `EPT_ADDR_COUNT, 32'h0000_0000);
		rdChk("period", `EPT_ADDR_PERIOD, 32'h0000_00FF);
		$display("test reset done");
		giveVerdict;
	end
endmodule // ept_period_timer_bench
